/* core/adsq_pkg.sv */
package adsq_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] ADSQ_IDX_CTRL = 8'h93;
  localparam logic [7:0] ADSQ_IDX_RES_LO = 8'h94;
  localparam logic [7:0] ADSQ_IDX_RES_HI = 8'h95;
  localparam logic [7:0] ADSQ_IDX_CTRL2 = 8'h96;
  localparam logic [7:0] ADSQ_IDX_THRESH = 8'h97;
  localparam logic [7:0] ADSQ_IDX_EXT = 8'h98;
  // control register fields
  localparam int ADSQ_CTRL_PD_BIT = 7;
  localparam int ADSQ_CTRL_MODE_LSB = 4;
  localparam int ADSQ_CTRL_REF_BIT = 3;
  localparam int ADSQ_CTRL_RUN_BIT = 2;
  localparam int ADSQ_CTRL_SEL_LSB = 0;
  // control two fields
  localparam int ADSQ_CTRL2_IE_BIT = 7;
  localparam int ADSQ_CTRL2_IF_BIT = 6;
  localparam int ADSQ_CTRL2_DIV_LSB = 0;
  // external enable / shared flag register fields
  localparam int ADSQ_EXT_IE_BIT = 0;
  localparam int ADSQ_EXT_IF_BIT = 1;
  // reset values
  localparam logic ADSQ_RST_PD = 1'b1;
  localparam logic [7:0] ADSQ_RST_BYTE = 8'h00;
  localparam logic [5:0] ADSQ_RST_DIV = 6'h00;
  localparam logic [9:0] ADSQ_RST_RESULT = 10'h000;
  // timing
  localparam int ADSQ_DIV_STEP = 16;
  localparam logic [3:0] ADSQ_CONV_LAST = 4'hA;
  // input select codes
  localparam logic [1:0] ADSQ_SEL_EXTREF = 2'h3;

  typedef enum logic [1:0] {
    ADSQ_MODE_SINGLE = 2'h0,
    ADSQ_MODE_CONT = 2'h1,
    ADSQ_MODE_STOP = 2'h2,
    ADSQ_MODE_RESET = 2'h3
  } adsq_mode_t;

  typedef enum logic [1:0] {
    ADSQ_ST_IDLE = 2'h1,
    ADSQ_ST_CONV = 2'h2
  } adsq_state_t;
endpackage : adsq_pkg

/* core/adsq_top.sv */
// Our own choice: the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - power-down bit 7, resets to one
// - mode 00: one conversion then stop
// - mode 01: flag on hit, keep converting
// - mode 10: flag on hit, then stop
// - mode 11: reset request on hit, no flag
// - reference bit: supply or internal 1.25 V
// - writing run starts the selected mode
// - single mode clears run when done
// - run cleared: halt after current conversion
// - stopping mode clears run on hit
// - input select routes inputs zero, one, two
// - code 11: input zero with external reference
// - low byte holds result bits 7:0
// - high bits latched on low byte read
// - interrupt needs local and external enable
// - flags stay set until software clears
// - divider is 16 times field plus one
// - hit when upper eight bits >= threshold
// - conversion takes eleven converter clocks
// - result survives the system reset request
module adsq_top
  import adsq_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] conv_data_in,
  output logic conv_clk_out,
  output logic conv_start,
  output logic converter_power_down,
  output logic [1:0] input_select,
  output logic ref_internal,
  output logic ref_external,
  output logic sys_reset_req,
  output logic irq
);

  typedef struct packed {
    logic pd;
    adsq_mode_t mode;
    logic refsel;
    logic run;
    logic [1:0] sel;
    logic lie;
    logic lif;
    logic [5:0] div;
    logic [7:0] thresh;
    logic eie;
    logic sif;
    logic [9:0] result;
    logic [1:0] hi_latch;
    adsq_state_t state;
    logic [9:0] div_cnt;
    logic [3:0] bit_cnt;
    logic conv_clk;
    logic start;
    logic rst_req;
    logic irq;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic refi;
    logic refe;
  } adsq_state_s_t;

  adsq_state_s_t s_q;
  adsq_state_s_t s_d;

  logic [7:0] idx;
  logic addr_ok;
  logic setup;
  logic access;
  logic wr;
  logic [10:0] div_len;
  logic tick;
  logic hit;
  logic done;
  logic [7:0] ctrl_rd;
  logic [7:0] ctrl2_rd;

  always_comb begin
    idx = paddr[9:2];
    addr_ok = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0) &&
              (idx >= ADSQ_IDX_CTRL) && (idx <= ADSQ_IDX_EXT);
    setup = psel && !penable;
    access = psel && penable && s_q.ready;
    wr = access && pwrite && addr_ok;
    div_len = 11'(ADSQ_DIV_STEP) * (11'(s_q.div) + 11'h001);
    tick = (11'(s_q.div_cnt) == div_len - 11'h001);
    done = tick && (s_q.state == ADSQ_ST_CONV) && (s_q.bit_cnt == ADSQ_CONV_LAST);
    hit = conv_data_in[9:2] >= s_q.thresh;
    ctrl_rd = {s_q.pd, 1'b0, s_q.mode, s_q.refsel, s_q.run, s_q.sel};
    ctrl2_rd = {s_q.lie, s_q.lif, s_q.div};

    s_d = s_q;
    s_d.start = 1'b0;
    s_d.rst_req = 1'b0;

    // converter clock divider
    if (s_q.pd) begin
      s_d.div_cnt = 10'h000;
      s_d.conv_clk = 1'b0;
    end else begin
      if (tick) begin
        s_d.div_cnt = 10'h000;
      end else begin
        s_d.div_cnt = s_q.div_cnt + 10'h001;
      end
      s_d.conv_clk = (11'(s_d.div_cnt) < {1'b0, div_len[10:1]});
    end

    // apb response, answered in the access phase
    s_d.ready = setup;
    if (setup) begin
      s_d.slverr = !addr_ok;
      s_d.rdata = 32'h00000000;
      if (addr_ok) begin
        case (idx)
          ADSQ_IDX_CTRL: s_d.rdata = {24'h000000, ctrl_rd};
          ADSQ_IDX_RES_LO: s_d.rdata = {24'h000000, s_q.result[7:0]};
          ADSQ_IDX_RES_HI: s_d.rdata = {30'h00000000, s_q.hi_latch};
          ADSQ_IDX_CTRL2: s_d.rdata = {24'h000000, ctrl2_rd};
          ADSQ_IDX_THRESH: s_d.rdata = {24'h000000, s_q.thresh};
          ADSQ_IDX_EXT: s_d.rdata = {30'h00000000, s_q.sif, s_q.eie};
          default: s_d.rdata = 32'h00000000;
        endcase
      end
    end else begin
      s_d.slverr = 1'b0;
    end
    if (access && !pwrite && addr_ok && idx == ADSQ_IDX_RES_LO) begin
      s_d.hi_latch = s_q.result[9:8];
    end

    // register writes
    if (wr) begin
      case (idx)
        ADSQ_IDX_CTRL: begin
          s_d.pd = pwdata[ADSQ_CTRL_PD_BIT];
          s_d.mode = adsq_mode_t'(pwdata[ADSQ_CTRL_MODE_LSB +: 2]);
          s_d.refsel = pwdata[ADSQ_CTRL_REF_BIT];
          s_d.run = pwdata[ADSQ_CTRL_RUN_BIT];
          s_d.sel = pwdata[ADSQ_CTRL_SEL_LSB +: 2];
        end
        ADSQ_IDX_CTRL2: begin
          s_d.lie = pwdata[ADSQ_CTRL2_IE_BIT];
          s_d.lif = pwdata[ADSQ_CTRL2_IF_BIT];
          s_d.div = pwdata[ADSQ_CTRL2_DIV_LSB +: 6];
        end
        ADSQ_IDX_THRESH: s_d.thresh = pwdata[7:0];
        ADSQ_IDX_EXT: begin
          s_d.eie = pwdata[ADSQ_EXT_IE_BIT];
          s_d.sif = pwdata[ADSQ_EXT_IF_BIT];
        end
        default: s_d.thresh = s_q.thresh;
      endcase
    end

    // conversion sequencer
    case (s_q.state)
      ADSQ_ST_IDLE: begin
        s_d.bit_cnt = 4'h0;
        if (tick && s_q.run && !s_q.pd) begin
          s_d.state = ADSQ_ST_CONV;
          s_d.start = 1'b1;
        end
      end
      ADSQ_ST_CONV: begin
        if (s_q.pd) begin
          s_d.state = ADSQ_ST_IDLE;
        end else if (done) begin
          s_d.bit_cnt = 4'h0;
          s_d.result = conv_data_in;
          if (hit && s_q.mode != ADSQ_MODE_RESET) begin
            s_d.lif = 1'b1;
            s_d.sif = 1'b1;
          end
          if (hit && s_q.mode == ADSQ_MODE_RESET) begin
            s_d.rst_req = 1'b1;
          end
          // software setting run in the same cycle wins over the hardware clear
          if (s_q.mode == ADSQ_MODE_SINGLE) begin
            s_d.state = ADSQ_ST_IDLE;
            if (!(wr && idx == ADSQ_IDX_CTRL)) begin
              s_d.run = 1'b0;
            end
          end else if (s_q.mode == ADSQ_MODE_STOP && hit) begin
            s_d.state = ADSQ_ST_IDLE;
            if (!(wr && idx == ADSQ_IDX_CTRL)) begin
              s_d.run = 1'b0;
            end
          end else if (s_d.run) begin
            s_d.start = 1'b1;
          end else begin
            s_d.state = ADSQ_ST_IDLE;
          end
        end else if (tick) begin
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        end
      end
      default: s_d.state = ADSQ_ST_IDLE;
    endcase

    // power-down wins over a start in the same cycle
    if (s_d.pd) begin
      s_d.start = 1'b0;
      s_d.state = ADSQ_ST_IDLE;
    end

    s_d.irq = s_d.lif && s_d.lie && s_d.eie;
    s_d.refi = s_d.refsel && (s_d.sel != ADSQ_SEL_EXTREF);
    s_d.refe = (s_d.sel == ADSQ_SEL_EXTREF);
  end

  // result holds across the reset request; only sys_rst clears it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{
        pd: ADSQ_RST_PD,
        mode: ADSQ_MODE_SINGLE,
        refsel: 1'b0,
        run: 1'b0,
        sel: 2'h0,
        lie: 1'b0,
        lif: 1'b0,
        div: ADSQ_RST_DIV,
        thresh: ADSQ_RST_BYTE,
        eie: 1'b0,
        sif: 1'b0,
        result: ADSQ_RST_RESULT,
        hi_latch: 2'h0,
        state: ADSQ_ST_IDLE,
        div_cnt: 10'h000,
        bit_cnt: 4'h0,
        conv_clk: 1'b0,
        start: 1'b0,
        rst_req: 1'b0,
        irq: 1'b0,
        rdata: 32'h00000000,
        ready: 1'b0,
        slverr: 1'b0,
        refi: 1'b0,
        refe: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign conv_clk_out = s_q.conv_clk;
  assign conv_start = s_q.start;
  assign converter_power_down = s_q.pd;
  assign input_select = s_q.sel;
  assign ref_internal = s_q.refi;
  assign ref_external = s_q.refe;
  assign sys_reset_req = s_q.rst_req;
  assign irq = s_q.irq;

endmodule : adsq_top

/* verif/adsq_conv_model.sv */
`timescale 1ns/1ps
module adsq_conv_model
  import adsq_pkg::*;
(
  input wire logic core_clk,
  input wire logic conv_start,
  input wire logic converter_power_down,
  input wire logic [1:0] input_select,
  input wire logic [2:0][9:0] levels,
  output logic [9:0] conv_data_in
);
  logic [9:0] held_q = 10'h000;
  // sample the routed input at conversion start
  always @(posedge core_clk) begin
    if (conv_start) begin
      held_q <= levels[input_select == ADSQ_SEL_EXTREF ? 2'h0 : input_select];
    end
  end
  // powered down core gives no valid result
  assign conv_data_in = converter_power_down ? ~held_q : held_q;
endmodule : adsq_conv_model

/* verif/adsq_props.sv */
`timescale 1ns/1ps
module adsq_props
  import adsq_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_start,
  input wire logic converter_power_down,
  input wire logic [1:0] input_select,
  input wire logic ref_internal,
  input wire logic ref_external,
  input wire logic sys_reset_req,
  input wire logic irq
);
  logic ext_en_q;
  logic [1:0] mode_q;
  logic [9:0] gap_q;
  wire wr_ok = psel && penable && pready && pwrite && !pslverr;
  // shadow of written external enable and mode, cycles since last start
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_en_q <= 1'b0;
      mode_q <= 2'h0;
      gap_q <= 10'h3FF;
    end else begin
      if (wr_ok && paddr[9:2] == ADSQ_IDX_EXT) ext_en_q <= pwdata[ADSQ_EXT_IE_BIT];
      if (wr_ok && paddr[9:2] == ADSQ_IDX_CTRL) mode_q <= pwdata[5:4];
      gap_q <= conv_start ? 10'h001 : (gap_q == 10'h3FF ? gap_q : gap_q + 10'h001);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  setup_ready_a: assert property (setup_s |=> access_s)
    else $error("no ready after setup");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  pd_idle_a: assert property (conv_start |-> !converter_power_down)
    else $error("start while powered down");
  start_gap_a: assert property (conv_start |-> gap_q >= 10'h0B0)
    else $error("conversions too close");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  reset_mode_a: assert property (sys_reset_req |-> mode_q == 2'h3 ##1 !sys_reset_req)
    else $error("reset request out of mode");
  irq_gate_a: assert property (irq |-> ext_en_q || $past(ext_en_q))
    else $error("irq without external enable");
  ref_ext_a: assert property (ref_external |-> input_select == 2'h3 && !ref_internal)
    else $error("external reference misrouted");
  ref_int_a: assert property (ref_internal |-> input_select != 2'h3)
    else $error("internal reference with code 11");
endmodule : adsq_props

bind adsq_top adsq_props u_props (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .conv_start, .converter_power_down, .input_select,
  .ref_internal, .ref_external, .sys_reset_req, .irq);

/* verif/tb_adc_sequencer_control.sv */
`timescale 1ns/1ps
module tb_adc_sequencer_control
  import adsq_pkg::*;
;
  logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, seed = 32'h5CD96A2D;
  logic pready, pslverr, conv_clk_out, conv_start, converter_power_down, ref_internal;
  logic ref_external, sys_reset_req, irq, saw_rst = 1'b0;
  logic [1:0] input_select;
  logic [9:0] conv_data_in;
  logic [2:0][9:0] levels = '0;
  logic [32:0] exp_q[$];
  time t_prev = 0, t_last = 0;
  int miscompares = 0, n_checks = 0;
  always #5 core_clk = ~core_clk;
  adsq_top dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conv_data_in, .conv_clk_out, .conv_start, .converter_power_down,
    .input_select, .ref_internal, .ref_external, .sys_reset_req, .irq);
  adsq_conv_model u_model (.core_clk, .conv_start, .converter_power_down, .input_select,
    .levels, .conv_data_in);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // one apb transfer; reads note their expected {pslverr, prdata}
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
    input logic [32:0] e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    if (!w) exp_q.push_back(e);
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  always @(posedge core_clk) begin
    if (pready === 1'b1 && psel && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
  end
  always @(posedge conv_start) begin
    t_prev = t_last;
    t_last = $time;
  end
  always @(posedge sys_reset_req) saw_rst = 1'b1;
  initial begin
    #600000;
    miscompares++;
    end_of_test;
  end
  initial begin
    logic [9:0] s;
    logic [7:0] dv;
    logic [7:0] c;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(0, ADSQ_IDX_CTRL, 8'h00, 33'h80);
    apb(0, ADSQ_IDX_CTRL2, 8'h00, 33'h0);
    apb(0, ADSQ_IDX_RES_LO, 8'h00, 33'h0);
    apb(0, ADSQ_IDX_RES_HI, 8'h00, 33'h0);
    apb(0, 8'h99, 8'h00, 33'h100000000);
    apb(1, ADSQ_IDX_CTRL, 8'h40, 33'h0);
    apb(0, ADSQ_IDX_CTRL, 8'h00, 33'h0);
    for (int m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      s = seed[9:0];
      dv = 8'h18 + {7'h0, seed[12]};
      levels[m == 3 ? 0 : m] = s;
      c = {2'h0, m[1:0], m[0], 1'h1, m[1:0]};
      apb(1, ADSQ_IDX_THRESH, s[9:2], 33'h0);
      apb(1, ADSQ_IDX_CTRL2, 8'h80 | dv, 33'h0);
      apb(1, ADSQ_IDX_EXT, 8'h01, 33'h0);
      apb(1, ADSQ_IDX_CTRL, c, 33'h0);
      @(posedge conv_start);
      repeat (176 * (dv + 1) + 3) @(posedge core_clk);
      #1;
      chk({28'h0, input_select, ref_internal, ref_external, irq},
        {28'h0, m[1:0], m == 1, m == 3, m != 3});
      if (m == 1) chk(33'(t_last - t_prev), 33'(1760 * (dv + 1)));
      chk({32'h0, saw_rst}, {32'h0, m == 3});
      apb(0, ADSQ_IDX_CTRL, 8'h00, {25'h0, c & (m[0] ? 8'hFF : 8'hFB)});
      apb(0, ADSQ_IDX_RES_LO, 8'h00, {25'h0, s[7:0]});
      apb(0, ADSQ_IDX_RES_HI, 8'h00, {31'h0, s[9:8]});
      apb(0, ADSQ_IDX_CTRL2, 8'h00, {25'h0, 8'h80 | dv | (m != 3 ? 8'h40 : 8'h00)});
      apb(1, ADSQ_IDX_CTRL, 8'h80, 33'h0);
      apb(1, ADSQ_IDX_EXT, 8'h01, 33'h0);
      apb(1, ADSQ_IDX_CTRL2, 8'h80 | dv, 33'h0);
      repeat (2) @(posedge core_clk);
      #1;
      chk({31'h0, irq, conv_clk_out}, 33'h0);
    end
    end_of_test;
  end
endmodule : tb_adc_sequencer_control
